/* core/cowd_top.sv */
// Code-option watchdog with reset, divider clamp and irq vector
`timescale 1ns/1ps
module cowd_top
#(
   parameter int WDT_W = cowd_pkg::COWD_WDT_W
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire cowd_pkg::cowd_wdmode_e wd_option,
   input wire logic noise_filter,
   input wire cowd_pkg::cowd_pmode_e power_mode,
   input wire logic wdt_clear,
   input wire logic [2:0] div_req,
   input wire logic irq_accept,
   output logic sys_reset,
   output logic [WDT_W-1:0] wdt_count,
   output logic wdt_running,
   output logic [2:0] cpu_div,
   output cowd_pkg::cowd_irq_s irq_out
);

   typedef struct packed {
      logic [WDT_W-1:0] cnt;
      logic run;
      logic [2:0] rst_cnt;
      logic rst;
      logic [2:0] div;
      cowd_pkg::cowd_irq_s irq;
      logic live;
   } cowd_state_s;

   cowd_state_s st_reg;
   cowd_state_s st_next;
   logic [2:0] div_eff;
   logic active;
   logic ovf;

   cowd_divsel u_divsel
   (
      .noise_filter(noise_filter),
      .div_req(div_req),
      .div_eff(div_eff)
   );

   function automatic logic wd_active(cowd_pkg::cowd_wdmode_e m,
                                      cowd_pkg::cowd_pmode_e p);
      unique case (m)
         cowd_pkg::COWD_WD_ENABLE:
            wd_active = (p == cowd_pkg::COWD_PM_NORMAL);
         cowd_pkg::COWD_WD_ALWAYS:
            wd_active = 1'b1;
         cowd_pkg::COWD_WD_DISABLE:
            wd_active = 1'b0;
         default: wd_active = 1'b0;
      endcase
   endfunction

   always_comb
   begin
      active = wd_active(wd_option, power_mode);
      ovf = active && (&st_reg.cnt);
      st_next = st_reg;
      st_next.live = 1'b1;
      st_next.run = active;
      st_next.div = div_eff;
      st_next.irq.irq_take = irq_accept;
      st_next.irq.irq_pc = irq_accept ? cowd_pkg::COWD_IRQ_VECTOR
                                      : st_reg.irq.irq_pc;
      // Counter only clears by software or at overflow; halts keep value
      if (!active)
      begin
         st_next.cnt = st_reg.cnt;
      end
      else if (wdt_clear || ovf)
      begin
         st_next.cnt = '0;
      end
      else
      begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
      // Reset pulse stretched so the whole system sees it
      if (ovf)
      begin
         st_next.rst = 1'b1;
         st_next.rst_cnt = cowd_pkg::COWD_RST_LEN_W;
      end
      else if (st_reg.rst_cnt != 3'h0)
      begin
         st_next.rst_cnt = st_reg.rst_cnt - 3'h1;
         st_next.rst = (st_reg.rst_cnt != 3'h1);
      end
      else
      begin
         st_next.rst = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
      end
      else if (ce)
      begin
         st_reg <= st_next;
      end
   end

   assign sys_reset = st_reg.rst;
   assign wdt_count = st_reg.cnt;
   assign wdt_running = st_reg.run;
   assign cpu_div = st_reg.div;
   assign irq_out = st_reg.irq;

   // Checks wait one clock after reset; the releasing edge still resets
   a_ovf_reset: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && active && (&st_reg.cnt))
      |=> sys_reset)
      else $error("overflow did not raise reset");

   a_pulse_hold: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && ovf) ##1 ce[*3]
      |=> sys_reset)
      else $error("reset pulse ended early");

   a_pulse_end: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && ovf) ##1 ce[*4]
      |=> !sys_reset)
      else $error("reset pulse too long");

   a_enable_halt: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && wd_option == cowd_pkg::COWD_WD_ENABLE
       && power_mode != cowd_pkg::COWD_PM_NORMAL)
      |=> $stable(wdt_count))
      else $error("enabled watchdog counted while idle");

   a_green_quiet: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && wd_option == cowd_pkg::COWD_WD_ENABLE && !sys_reset
       && power_mode != cowd_pkg::COWD_PM_NORMAL)
      |=> !sys_reset)
      else $error("enabled watchdog reset while idle");

   a_wake_count: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && wd_option == cowd_pkg::COWD_WD_ENABLE && !wdt_clear
       && power_mode == cowd_pkg::COWD_PM_NORMAL && !(&wdt_count))
      |=> wdt_count == $past(wdt_count) + 1'b1)
      else $error("enabled watchdog not counting when running");

   a_clear_zero: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && active && wdt_clear)
      |=> wdt_count == '0)
      else $error("software clear did not restart counter");

   a_always_count: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && wd_option == cowd_pkg::COWD_WD_ALWAYS && !wdt_clear
       && power_mode != cowd_pkg::COWD_PM_NORMAL && !(&wdt_count))
      |=> wdt_count == $past(wdt_count) + 1'b1)
      else $error("always-on watchdog paused while idle");

   a_always_rst: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && wd_option == cowd_pkg::COWD_WD_ALWAYS && (&wdt_count))
      |=> sys_reset ##1 (sys_reset || !ce))
      else $error("always-on overflow missed reset");

   a_div_range: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && noise_filter)
      |=> cpu_div >= cowd_pkg::COWD_DIV_MIN_NF)
      else $error("divider below filtered minimum");

   a_div_raw: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && !noise_filter)
      |=> cpu_div == $past(div_req))
      else $error("unfiltered divider not passed through");

   a_div_pass: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && div_req >= cowd_pkg::COWD_DIV_MIN_NF)
      |=> cpu_div == $past(div_req))
      else $error("legal divider request altered");

   a_irq_vector: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && irq_accept)
      |=> irq_out.irq_take && irq_out.irq_pc == cowd_pkg::COWD_IRQ_VECTOR)
      else $error("interrupt vector not loaded");

   a_irq_quiet: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && !irq_accept)
      |=> !irq_out.irq_take)
      else $error("interrupt taken without request");

   a_disable_quiet: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && wd_option == cowd_pkg::COWD_WD_DISABLE && !sys_reset)
      |=> !sys_reset && !wdt_running)
      else $error("disabled watchdog active");

   a_disable_hold: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      (ce && wd_option == cowd_pkg::COWD_WD_DISABLE)
      |=> $stable(wdt_count))
      else $error("disabled watchdog counter moved");

   // Clock enable must freeze every bit of state
   a_ce_freeze: assert property (
      @(posedge mclk) disable iff (!rstn || !st_reg.live)
      !ce
      |=> $stable(st_reg))
      else $error("state changed with clock enable low");
endmodule // cowd_top

/* core/cowd_pkg.sv */
// Shared types and constants of the code-option watchdog
package cowd_pkg;

   // Watchdog code option settings
   typedef enum logic [1:0] {
      COWD_WD_DISABLE = 2'b00,
      COWD_WD_ENABLE = 2'b01,
      COWD_WD_ALWAYS = 2'b10
   } cowd_wdmode_e;

   // Power modes of the core
   typedef enum logic [1:0] {
      COWD_PM_NORMAL = 2'b00,
      COWD_PM_GREEN = 2'b01,
      COWD_PM_SLEEP = 2'b10
   } cowd_pmode_e;

   // Divider exponent: cpu clock is osc / 2**exp
   localparam int COWD_DIV_W = 3;
   localparam logic [2:0] COWD_DIV_MIN_NF = 3'h2;
   localparam logic [2:0] COWD_DIV_MIN_RAW = 3'h0;
   localparam logic [2:0] COWD_DIV_MAX = 3'h7;

   // Interrupt vector location
   localparam int COWD_PC_W = 12;
   localparam logic [11:0] COWD_IRQ_VECTOR = 12'h008;

   // Watchdog counter defaults
   localparam int COWD_WDT_W = 16;
   localparam int COWD_RST_LEN = 4;
   localparam logic [2:0] COWD_RST_LEN_W = 3'h4;

   typedef struct packed {
      logic irq_take;
      logic [11:0] irq_pc;
   } cowd_irq_s;

endpackage

/* core/cowd_divsel.sv */
// Clamp of the cpu clock divider to the range allowed by the noise filter
`timescale 1ns/1ps
module cowd_divsel
(
   input wire logic noise_filter,
   input wire logic [2:0] div_req,
   output logic [2:0] div_eff
);
   logic [2:0] lo;

   always_comb
   begin
      lo = noise_filter ? cowd_pkg::COWD_DIV_MIN_NF
                        : cowd_pkg::COWD_DIV_MIN_RAW;
      if (div_req < lo)
      begin
         div_eff = lo;
      end
      else
      begin
         div_eff = div_req;
      end
   end
endmodule // cowd_divsel

/* tb/cowd_top_tb.sv */
// Self-checking bench of the code-option watchdog
`timescale 1ns/1ps
module cowd_top_tb;
   localparam int W = 4;
   logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, noise_filter = 1'b0;
   logic wdt_clear = 1'b0, irq_accept = 1'b0, sys_reset, wdt_running;
   logic [2:0] div_req = 3'h0, cpu_div;
   logic [W-1:0] wdt_count, held;
   cowd_pkg::cowd_wdmode_e wd_option = cowd_pkg::COWD_WD_DISABLE;
   cowd_pkg::cowd_pmode_e power_mode = cowd_pkg::COWD_PM_NORMAL;
   cowd_pkg::cowd_irq_s irq_out;
   int miscompares = 0, total_checks = 0, cycles = 0, n;
   // Rows: filter, request, expected exponent
   logic [6:0] rows [6] = '{7'h42, 7'h4A, 7'h5B, 7'h7F, 7'h00, 7'h09};
   cowd_top #(.WDT_W(W)) u_cowd_top (.mclk(mclk), .rstn(rstn), .ce(ce),
      .wd_option(wd_option), .noise_filter(noise_filter),
      .power_mode(power_mode), .wdt_clear(wdt_clear), .div_req(div_req),
      .irq_accept(irq_accept), .sys_reset(sys_reset),
      .wdt_count(wdt_count), .wdt_running(wdt_running),
      .cpu_div(cpu_div), .irq_out(irq_out));
   always #5 mclk = ~mclk;
   task automatic final_report;
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles needed
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // Option is static, so each change goes through a reset
   task automatic go(input cowd_pkg::cowd_wdmode_e m,
                     input cowd_pkg::cowd_pmode_e p);
      @(posedge mclk);
      rstn <= 1'b0;
      wd_option <= m;
      power_mode <= p;
      tick(1);
      @(posedge mclk) rstn <= 1'b1;
      #1;
   endtask
   task automatic power(input cowd_pkg::cowd_pmode_e p);
      @(posedge mclk) power_mode <= p;
      #1;
   endtask
   // Overflow due within 2**W + 1 cycles, then a 4-cycle pulse
   task automatic overflow;
      n = 0;
      while (sys_reset !== 1'b1 && n < 40)
      begin
         tick(1);
         n++;
      end
      chk(12'(n <= 17), 12'h1);
      tick(3);
      chk(12'(sys_reset), 12'h1);
      tick(1);
      chk(12'(sys_reset), 12'h0);
   endtask
   initial
   begin
      tick(3);
      chk(12'({sys_reset, wdt_running, cpu_div}), 12'h0);
      @(posedge mclk) rstn <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         @(posedge mclk) {noise_filter, div_req} <= rows[i][6:3];
         tick(1);
         chk(12'(cpu_div), 12'(rows[i][2:0]));
      end
      @(posedge mclk) irq_accept <= 1'b1;
      @(posedge mclk) irq_accept <= 1'b0;
      #1;
      chk(12'(irq_out.irq_take), 12'h1);
      chk(irq_out.irq_pc, cowd_pkg::COWD_IRQ_VECTOR);
      tick(1);
      chk(12'(irq_out.irq_take), 12'h0);
      chk(irq_out.irq_pc, cowd_pkg::COWD_IRQ_VECTOR);
      go(cowd_pkg::COWD_WD_ENABLE, cowd_pkg::COWD_PM_NORMAL);
      tick(5);
      power(cowd_pkg::COWD_PM_GREEN);
      tick(2);
      held = wdt_count;
      tick(40);
      chk(12'(wdt_count), 12'(held));
      chk(12'(sys_reset), 12'h0);
      power(cowd_pkg::COWD_PM_SLEEP);
      // Clear is ignored while the counter is halted
      @(posedge mclk) wdt_clear <= 1'b1;
      tick(40);
      chk(12'(wdt_count), 12'(held));
      @(posedge mclk) wdt_clear <= 1'b0;
      power(cowd_pkg::COWD_PM_NORMAL);
      tick(3);
      chk(12'(wdt_count != held), 12'h1);
      @(posedge mclk) wdt_clear <= 1'b1;
      @(posedge mclk) wdt_clear <= 1'b0;
      #1;
      chk(12'(wdt_count), 12'h0);
      overflow();
      go(cowd_pkg::COWD_WD_ALWAYS, cowd_pkg::COWD_PM_SLEEP);
      tick(2);
      held = wdt_count;
      tick(1);
      chk(12'(wdt_count), 12'(held + 1'b1));
      overflow();
      power(cowd_pkg::COWD_PM_GREEN);
      overflow();
      // Clock enable low freezes the running counter
      @(posedge mclk) ce <= 1'b0;
      tick(1);
      held = wdt_count;
      tick(5);
      chk(12'(wdt_count), 12'(held));
      @(posedge mclk) ce <= 1'b1;
      tick(1);
      chk(12'(wdt_count), 12'(held + 1'b1));
      go(cowd_pkg::COWD_WD_DISABLE, cowd_pkg::COWD_PM_NORMAL);
      tick(40);
      chk(12'(sys_reset), 12'h0);
      chk(12'(wdt_count), 12'h0);
      chk(12'(wdt_running), 12'h0);
      final_report();
   end
endmodule // cowd_top_tb
